// File: core/rdar_regs.sv
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module rdar_regs
    import rdar_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic [ADDR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [31:0]        cur_time,
    input  wire logic               half_sec_tick,
    input  wire logic               sec_tick,
    input  wire logic               date_load,
    input  wire logic [31:0]        date_load_val,
    output logic [31:0]             date_value,
    output logic                    alarm_enable_bit,
    output logic                    alarm_event,
    output logic                    alarm_pulse,
    output logic                    irq
);

    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_bad_addr
        $error("rdar_regs: ADDR_W must lie in 5..32");
    end

    rdar_state_t s_q;
    rdar_state_t s_d;

    // byte-lane merge, keeping unimplemented bits at zero
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel,
        input logic [31:0] impl
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r & impl;
    endfunction : lane_merge

    // compare a field window of two words
    function automatic logic fld_eq(
        input logic [31:0] a,
        input logic [31:0] b,
        input logic [31:0] m
    );
        return (a & m) == (b & m);
    endfunction : fld_eq

    logic [ADDR_W-1:0] adr_lo;
    logic              req;
    logic              wr;
    logic [7:0]        ofs;
    logic [31:0]       sec_m;
    logic [31:0]       secu_m;
    logic [31:0]       min_m;
    logic [31:0]       minu_m;
    logic [31:0]       hr_m;
    logic [31:0]       day_m;
    logic [31:0]       wday_m;
    logic [31:0]       mon_m;
    logic              t_sec;
    logic              t_secu;
    logic              t_min;
    logic              t_minu;
    logic              t_hr;
    logic              d_day;
    logic              d_wday;
    logic              d_mon;
    logic              match;
    logic              fire;
    logic [31:0]       ctrl_word;
    logic [31:0]       rd_word;
    rdar_alarm_field_mask_t       am;

    always_comb
    begin
        adr_lo = wb_adr_i;
        ofs    = 8'(adr_lo);
        req    = wb_cyc_i && wb_stb_i && !s_q.ack;
        wr     = req && wb_we_i;

        // field windows of the alarm compare words
        secu_m = 32'h0000_000F << SEC_U_LSB;
        sec_m  = secu_m | (32'h0000_0007 << SEC_T_LSB);
        minu_m = 32'h0000_000F << MIN_U_LSB;
        min_m  = minu_m | (32'h0000_0007 << MIN_T_LSB);
        hr_m   = (32'h0000_000F << HR_U_LSB)
               | (32'h0000_0003 << HR_T_LSB);
        day_m  = (32'h0000_000F << DAY_U_LSB)
               | (32'h0000_0003 << DAY_T_LSB);
        wday_m = 32'h0000_0007 << WDAY_LSB;
        mon_m  = (32'h0000_000F << MON_U_LSB)
               | (32'h0000_0001 << MON_T_BIT);

        t_secu = fld_eq(cur_time, s_q.atime, secu_m);
        t_sec  = fld_eq(cur_time, s_q.atime, sec_m);
        t_minu = fld_eq(cur_time, s_q.atime, minu_m);
        t_min  = fld_eq(cur_time, s_q.atime, min_m);
        t_hr   = fld_eq(cur_time, s_q.atime, hr_m);
        d_day  = fld_eq(s_q.date, s_q.adate, day_m);
        d_wday = fld_eq(s_q.date, s_q.adate, wday_m);
        d_mon  = fld_eq(s_q.date, s_q.adate, mon_m);

        // from the ten-second code on, each coarser code adds the next field, but month compares the day in place of the weekday; reserved codes never fire
        am    = rdar_alarm_field_mask_t'(s_q.ctrl.alarm_field_mask);
        match = 1'b0;
        unique case (am)
            AM_HALF_SEC: match = half_sec_tick;
            AM_SEC:      match = sec_tick;
            AM_TEN_SEC:  match = sec_tick && t_secu;
            AM_MINUTE:   match = sec_tick && t_sec;
            AM_TEN_MIN:  match = sec_tick && t_sec && t_minu;
            AM_HOUR:     match = sec_tick && t_sec && t_min;
            AM_DAY:      match = sec_tick && t_sec && t_min && t_hr;
            AM_WEEK:     match = sec_tick && t_sec && t_min && t_hr && d_wday;
            AM_MONTH:    match = sec_tick && t_sec && t_min && t_hr && d_day;
            AM_YEAR:     match = sec_tick && t_sec && t_min && t_hr && d_day && d_mon;
            default:     match = 1'b0;
        endcase
        fire = s_q.ctrl.aen && match;

        ctrl_word = ZERO32;
        ctrl_word[CTL_UNLOCK_BIT]            = s_q.ctrl.unlock;
        ctrl_word[CTL_AEN_BIT]               = s_q.ctrl.aen;
        ctrl_word[CTL_CHIME_BIT]             = s_q.ctrl.chime;
        ctrl_word[CTL_MASK_LSB +: 4]         = s_q.ctrl.alarm_field_mask;
        ctrl_word[CTL_RPT_LSB +: 8]          = s_q.ctrl.rpt;

        // registers are stored masked, so unused bits read zero
        unique case (ofs)
            OFS_DATE:  rd_word = s_q.date  & DATE_IMPL;
            OFS_ATIME: rd_word = s_q.atime & ATIME_IMPL;
            OFS_ADATE: rd_word = s_q.adate & ADATE_IMPL;
            OFS_CTRL:  rd_word = ctrl_word;
            OFS_STAT:  rd_word = {{(32-ST_W){1'b0}}, s_q.stat};
            OFS_IMASK: rd_word = {{(32-ST_W){1'b0}}, s_q.imask};
            default:   rd_word = ZERO32;
        endcase
        if (adr_lo != ADDR_W'(ofs))
        begin
            rd_word = ZERO32;
        end

        s_d           = s_q;
        s_d.ack       = req;
        s_d.dat       = req ? rd_word : ZERO32;
        s_d.event_hit = fire;

        // calendar rollover from the counter chain outside
        if (date_load)
        begin
            s_d.date = date_load_val & DATE_IMPL;
        end

        // alarm sequencing; a bus write below overrides it
        if (fire)
        begin
            s_d.pulse = !s_q.pulse;
            if (s_q.ctrl.rpt == RPT_ZERO)
            begin
                if (s_q.ctrl.chime)
                begin
                    s_d.ctrl.rpt = RPT_WRAP;
                end
                else
                begin
                    s_d.ctrl.aen = 1'b0;
                end
            end
            else
            begin
                s_d.ctrl.rpt = s_q.ctrl.rpt - 8'h01;
            end
        end

        if (wr && adr_lo == ADDR_W'(ofs))
        begin
            unique case (ofs)
                OFS_DATE:
                begin
                    if (s_q.ctrl.unlock)
                    begin
                        s_d.date = lane_merge(s_q.date, wb_dat_i,
                                              wb_sel_i, DATE_IMPL);
                    end
                end
                OFS_ATIME:
                begin
                    s_d.atime = lane_merge(s_q.atime, wb_dat_i,
                                           wb_sel_i, ATIME_IMPL);
                end
                OFS_ADATE:
                begin
                    s_d.adate = lane_merge(s_q.adate, wb_dat_i,
                                           wb_sel_i, ADATE_IMPL);
                end
                OFS_CTRL:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_d.ctrl.rpt = wb_dat_i[CTL_RPT_LSB +: 8];
                    end
                    if (wb_sel_i[1])
                    begin
                        s_d.ctrl.alarm_field_mask = wb_dat_i[CTL_MASK_LSB +: 4];
                        s_d.ctrl.chime = wb_dat_i[CTL_CHIME_BIT];
                        s_d.ctrl.aen   = wb_dat_i[CTL_AEN_BIT];
                    end
                    if (wb_sel_i[2])
                    begin
                        s_d.ctrl.unlock = wb_dat_i[CTL_UNLOCK_BIT];
                    end
                end
                OFS_IMASK:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_d.imask = wb_dat_i[ST_W-1:0];
                    end
                end
                default:
                begin
                end
            endcase
        end

        // write-one-to-clear, then events set; a same-cycle set survives
        if (wr && ofs == OFS_STAT && adr_lo == ADDR_W'(ofs) && wb_sel_i[0])
        begin
            s_d.stat = s_q.stat & ~wb_dat_i[ST_W-1:0];
        end
        if (fire)
        begin
            s_d.stat[ST_ALARM_BIT] = 1'b1;
        end
        if (wr && ofs == OFS_DATE && adr_lo == ADDR_W'(ofs) && !s_q.ctrl.unlock)
        begin
            s_d.stat[ST_LOCKED_BIT] = 1'b1;
        end

        s_d.irq = |(s_d.stat & s_d.imask);
    end

    // power-on contents are undefined in silicon; zero keeps sim clean
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o         = s_q.dat;
    assign wb_ack_o         = s_q.ack;
    assign date_value       = s_q.date;
    assign alarm_enable_bit = s_q.ctrl.aen;
    assign alarm_event      = s_q.event_hit;
    assign alarm_pulse      = s_q.pulse;
    assign irq              = s_q.irq;

endmodule : rdar_regs

`default_nettype wire

// File: core/rdar_pkg.sv
`default_nettype none

package rdar_pkg;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_DATE   = 8'h00;
    localparam logic [7:0] OFS_ATIME  = 8'h04;
    localparam logic [7:0] OFS_ADATE  = 8'h08;
    localparam logic [7:0] OFS_CTRL   = 8'h0C;
    localparam logic [7:0] OFS_STAT   = 8'h10;
    localparam logic [7:0] OFS_IMASK  = 8'h14;

    // implemented bits of the date, alarm time, alarm date and control registers
    localparam logic [31:0] DATE_IMPL  = 32'hFF1F_3F07;
    localparam logic [31:0] ATIME_IMPL = 32'h3F7F_7F00;
    localparam logic [31:0] ADATE_IMPL = 32'h001F_3F07;
    localparam logic [31:0] CTRL_IMPL  = 32'h0001_CFFF;

    // field positions, shared by date and time words
    localparam int YR_T_LSB  = 28;
    localparam int YR_U_LSB  = 24;
    localparam int HR_T_LSB  = 28;
    localparam int HR_U_LSB  = 24;
    localparam int MIN_T_LSB = 20;
    localparam int MIN_U_LSB = 16;
    localparam int MON_T_BIT = 20;
    localparam int MON_U_LSB = 16;
    localparam int SEC_T_LSB = 12;
    localparam int SEC_U_LSB = 8;
    localparam int DAY_T_LSB = 12;
    localparam int DAY_U_LSB = 8;
    localparam int WDAY_LSB  = 0;

    // control register layout
    localparam int CTL_UNLOCK_BIT = 16;
    localparam int CTL_AEN_BIT    = 15;
    localparam int CTL_CHIME_BIT  = 14;
    localparam int CTL_MASK_LSB   = 8;
    localparam int CTL_RPT_LSB    = 0;

    // status / interrupt bits
    localparam int ST_ALARM_BIT  = 0;
    localparam int ST_LOCKED_BIT = 1;
    localparam int ST_W          = 2;

    localparam logic [31:0] ZERO32   = 32'h0000_0000;
    localparam logic [7:0]  RPT_WRAP = 8'hFF;
    localparam logic [7:0]  RPT_ZERO = 8'h00;

    typedef enum logic [3:0] {
        AM_HALF_SEC = 4'h0,
        AM_SEC      = 4'h1,
        AM_TEN_SEC  = 4'h2,
        AM_MINUTE   = 4'h3,
        AM_TEN_MIN  = 4'h4,
        AM_HOUR     = 4'h5,
        AM_DAY      = 4'h6,
        AM_WEEK     = 4'h7,
        AM_MONTH    = 4'h8,
        AM_YEAR     = 4'h9
    } rdar_alarm_field_mask_t;

    typedef struct packed {
        logic        aen;
        logic        chime;
        logic [3:0]  alarm_field_mask;
        logic [7:0]  rpt;
        logic        unlock;
    } rdar_ctrl_t;

    typedef struct packed {
        logic [31:0]     date;
        logic [31:0]     atime;
        logic [31:0]     adate;
        rdar_ctrl_t      ctrl;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] imask;
        logic            ack;
        logic [31:0]     dat;
        logic            irq;
        logic            pulse;
        logic            event_hit;
    } rdar_state_t;

endpackage : rdar_pkg

`default_nettype wire

// File: verif/rdar_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rdar_props
    import rdar_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic              wb_we_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [31:0]       cur_time,
    input wire logic              half_sec_tick,
    input wire logic              sec_tick,
    input wire logic              date_load,
    input wire logic [31:0]       date_load_val,
    input wire logic [31:0]       date_value,
    input wire logic              alarm_enable_bit,
    input wire logic              alarm_event,
    input wire logic              alarm_pulse,
    input wire logic              irq
);
    logic req;
    logic wr_date;
    logic tick_any;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_date = req && wb_we_i && wb_adr_i == ADDR_W'(OFS_DATE);
    assign tick_any = sec_tick || half_sec_tick;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    AST_ACK_RESP: assert property (req |=> wb_ack_o) else $error("no ack");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == ZERO32) else $error("dat idle");
    AST_DATE_RD: assert property (wb_ack_o && wb_adr_i == ADDR_W'(OFS_DATE)
        |-> (wb_dat_o & ~DATE_IMPL) == ZERO32) else $error("date pad bits");
    AST_ATIME_RD: assert property (wb_ack_o && wb_adr_i == ADDR_W'(OFS_ATIME)
        |-> (wb_dat_o & ~ATIME_IMPL) == ZERO32) else $error("alarm time pad bits");
    AST_ADATE_RD: assert property (wb_ack_o && wb_adr_i == ADDR_W'(OFS_ADATE)
        |-> (wb_dat_o & ~ADATE_IMPL) == ZERO32) else $error("alarm date pad bits");
    AST_DATE_VAL: assert property ((date_value & ~DATE_IMPL) == ZERO32)
        else $error("date value pad bits");
    AST_DATE_CHG: assert property ($changed(date_value)
        |-> $past(wr_date) || $past(date_load)) else $error("date changed unasked");
    AST_EVT_TICK: assert property (alarm_event |-> $past(tick_any))
        else $error("event without tick");
    AST_EVT_EN: assert property (alarm_event |-> $past(alarm_enable_bit))
        else $error("event while disabled");
    AST_EVT_PULSE: assert property (alarm_event |-> alarm_pulse != $past(alarm_pulse))
        else $error("pulse did not toggle");
endmodule : rdar_props
bind rdar_regs rdar_props #(.ADDR_W(ADDR_W)) rdar_props_i (.core_clk(core_clk), .rstn(rstn),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cur_time(cur_time), .half_sec_tick(half_sec_tick), .sec_tick(sec_tick),
    .date_load(date_load), .date_load_val(date_load_val), .date_value(date_value),
    .alarm_enable_bit(alarm_enable_bit), .alarm_event(alarm_event),
    .alarm_pulse(alarm_pulse), .irq(irq));
`default_nettype wire

// File: verif/rdar_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rdar_regs_tb_top
    import rdar_pkg::*;
;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ht = 0, st = 0, dl = 0;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = '0;
    logic [31:0] wd = '0, ct = '0, dlv = '0, rdat, dv, q;
    logic        ack, aen, ev, pl, irq;
    int          n_fail = 0, samples_checked = 0;
    rdar_regs rdar_regs_i (.core_clk(clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cur_time(ct), .half_sec_tick(ht), .sec_tick(st), .date_load(dl),
        .date_load_val(dlv), .date_value(dv), .alarm_enable_bit(aen), .alarm_event(ev),
        .alarm_pulse(pl), .irq(irq));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic c1(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask : c1
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, s};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 64);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n >= 64)
            c1(1'b0, 1'b1);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d, 4'hF);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, ZERO32, 4'hF);
        chk(q, e);
    endtask : rc
    function automatic logic [31:0] cw(input logic u, a, c, input logic [3:0] m,
                                       input logic [7:0] r);
        return {15'h0, u, a, c, 2'b00, m, r};
    endfunction : cw
    // one tick, event checked one cycle after it
    task automatic tick(input logic h, input logic e);
        @(posedge clk);
        {ht, st} <= h ? 2'b10 : 2'b01;
        @(posedge clk);
        {ht, st} <= 2'b00;
        @(negedge clk);
        c1(ev, e);
    endtask : tick
    task automatic t_reset;
        for (int a = 0; a <= 24; a += 4)
            rc(8'(a), ZERO32);
        wr(8'h18, 32'hFFFF_FFFF);
        rc(8'h18, ZERO32);
        rc(8'h01, ZERO32);
        $display("test reset done");
    endtask : t_reset
    task automatic t_date;
        wr(OFS_DATE, 32'h2512_3106);
        rc(OFS_DATE, ZERO32);
        rc(OFS_STAT, 32'h0000_0002);
        wr(OFS_STAT, 32'h0000_0002);
        rc(OFS_STAT, ZERO32);
        wr(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 4'h0, 8'h00));
        wr(OFS_DATE, 32'hFFFF_FFFF);
        rc(OFS_DATE, DATE_IMPL);
        wr(OFS_DATE, 32'h9919_3906);
        rc(OFS_DATE, 32'h9919_3906);
        wb(OFS_DATE, 1'b1, 32'h0000_0002, 4'h1);
        rc(OFS_DATE, 32'h9919_3902);
        @(posedge clk);
        {dl, dlv} <= {1'b1, 32'hFFFF_FFFF};
        @(posedge clk);
        dl <= 1'b0;
        @(negedge clk);
        chk(dv, DATE_IMPL);
        wr(OFS_DATE, 32'h9919_3906);
        chk(dv, 32'h9919_3906);
        $display("test date done");
    endtask : t_date
    task automatic t_alarm_regs;
        wr(OFS_ATIME, 32'hFFFF_FFFF);
        rc(OFS_ATIME, ATIME_IMPL);
        wr(OFS_ADATE, 32'hFFFF_FFFF);
        rc(OFS_ADATE, ADATE_IMPL);
        wr(OFS_ATIME, 32'h2359_5900);
        rc(OFS_ATIME, 32'h2359_5900);
        wr(OFS_ADATE, 32'h0019_3906);
        rc(OFS_ADATE, 32'h0019_3906);
        $display("test alarm regs done");
    endtask : t_alarm_regs
    task automatic t_alarm;
        wr(OFS_IMASK, 32'h0000_0001);
        ct <= 32'h2359_5900;
        for (int m = 0; m < 16; m++)
        begin
            wr(OFS_CTRL, cw(1'b0, 1'b1, 1'b1, 4'(m), 8'h05));
            tick(m == 0, m <= 9);
            if (m <= 9)
                rc(OFS_CTRL, cw(1'b0, 1'b1, 1'b1, 4'(m), 8'h04));
        end
        c1(irq, 1'b1);
        c1(aen, 1'b1);
        wr(OFS_IMASK, ZERO32);
        c1(irq, 1'b0);
        wr(OFS_IMASK, 32'h0000_0001);
        wr(OFS_STAT, 32'h0000_0001);
        c1(irq, 1'b0);
        ct <= 32'h2259_5700;
        wr(OFS_CTRL, cw(1'b0, 1'b1, 1'b0, 4'h2, 8'h01));
        tick(1'b0, 1'b0);
        ct <= 32'h2259_5900;
        // hour differs, so the daily code must stay quiet
        wr(OFS_CTRL, cw(1'b0, 1'b1, 1'b0, 4'h6, 8'h01));
        tick(1'b0, 1'b0);
        wr(OFS_CTRL, cw(1'b0, 1'b1, 1'b0, 4'h4, 8'h01));
        tick(1'b0, 1'b1);
        rc(OFS_CTRL, cw(1'b0, 1'b1, 1'b0, 4'h4, 8'h00));
        tick(1'b0, 1'b1);
        rc(OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 4'h4, 8'h00));
        c1(aen, 1'b0);
        tick(1'b0, 1'b0);
        wr(OFS_CTRL, cw(1'b0, 1'b1, 1'b1, 4'h1, 8'h00));
        tick(1'b0, 1'b1);
        rc(OFS_CTRL, cw(1'b0, 1'b1, 1'b1, 4'h1, 8'hFF));
        // thirteen events so far, so the pulse level ends high
        c1(pl, 1'b1);
        $display("test alarm done");
    endtask : t_alarm
    task final_report;
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_date;
        t_alarm_regs;
        t_alarm;
        final_report;
    end
    // limit well above the few hundred cycles the tests take
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report;
    end
endmodule : rdar_regs_tb_top
`default_nettype wire
